// [ddc_checker_assertions.sv]
// concurrent checks on the down converter ports
`timescale 1ns/10ps
module ddc_checker (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // control
  input wire logic               mixer_reload,
  input wire logic               sync_request,
  input wire logic               sync_enable,
  input wire logic               powerdown_align_pin,
  input wire logic [31:0]        osc_word_0,
  input wire logic [31:0]        osc_word_1,
  // status
  input wire logic               powerdown,
  input wire logic [31:0]        active_word_0,
  input wire logic [31:0]        active_word_1,
  // stream
  input wire logic               out_valid,
  input wire logic               out_ready,
  input wire logic signed [19:0] out_i,
  input wire logic signed [19:0] out_q,
  input wire logic               out_lane,
  input wire logic               out_is_complex
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // word held steady over the load window, else the expected value is ambiguous
  sequence reload_seq;
    $rose(mixer_reload) ##1 $stable(osc_word_0) [*2];
  endsequence
  sequence sync_seq;
    $rose(sync_request) ##1 $stable(osc_word_1) [*2];
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !out_valid && active_word_0 == 32'h0 && !powerdown) else $error("outputs busy after reset");
  a_reload_load: assert property (reload_seq |-> active_word_0 == osc_word_0)
    else $error("reload did not load word");
  a_sync_load: assert property (sync_seq |-> active_word_1 == osc_word_1)
    else $error("sync did not load word");
  a_word_hold: assert property ($changed(active_word_0) && !$past(rst) && !sync_enable
    && !$past(sync_enable, 4) |-> $past(mixer_reload) || $past(mixer_reload, 2) || $past(sync_request)
    || $past(sync_request, 2)) else $error("word changed without reload");
  a_pin_mask: assert property (sync_enable |-> !powerdown) else $error("powerdown while pin is sync");
  a_pin_powerdown: assert property ((powerdown_align_pin && !sync_enable) [*6] |-> powerdown)
    else $error("pin high but no powerdown");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i)
    && $stable(out_q) && $stable(out_lane)) else $error("word changed while stalled");
  a_real_q: assert property (out_valid && !out_is_complex |-> out_q == 20'h0)
    else $error("real word with q set");
endmodule // ddc_checker
bind ddc_core ddc_checker u_chk (.clk(clk), .rst(rst), .mixer_reload(mixer_reload), .sync_request(sync_request),
  .sync_enable(sync_enable), .powerdown_align_pin(powerdown_align_pin), .osc_word_0(osc_word_0),
  .osc_word_1(osc_word_1), .powerdown(powerdown), .active_word_0(active_word_0), .active_word_1(active_word_1),
  .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i), .out_q(out_q), .out_lane(out_lane),
  .out_is_complex(out_is_complex));

// [ddc_core.sv]
// dual band decimating down converter with input select and sync
`timescale 1ns/10ps
// Contract
// - complex decimation by 2 to 32 with mixer fed by 32-bit oscillator
// - real mode bypasses mixer, filter acts as low-pass decimator
// - internal arithmetic is 20 bits; formatter truncates later
// - input selector feeds two converters with independent oscillators
// - second converter output goes to second lane pair
// - complex mode: shift, low-pass around zero, then decimate by factor
// - optional 6 dB gain in complex mode
// - optional 3 dB gain in real mode
// - quarter-rate mode emits real samples at twice rate centred at quarter rate
// - oscillator rotates positive by default, negative when inverted
// - oscillator word is signed, one lsb is sample rate over 2^32
// - new word waits for reload rising edge or sync pin toggle
// - complex passband 0.8, real 0.4 of output rate
// - stop-band attenuation at least 85 dB in every setting; here only a boxcar, stop-band left to downstream
// - select bit turns power-down pin into sync input, sampled on clock
// - sync resets decimation dividers and aligns I and Q
// - sync also resets phase and loads pending word
// - bit mapping applies to both I and Q samples
module ddc_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // converter samples
  input  wire logic                 sample_valid,
  input  wire logic signed [13:0]   sample_a,
  input  wire logic signed [13:0]   sample_b,
  // control
  input  wire logic                 filter_enable,
  input  wire logic                 complex_mode,
  input  wire logic [2:0]           dec_select,
  input  wire logic                 gain_enable,
  input  wire logic                 quarter_rate_mode,
  input  wire logic                 phase_invert,
  input  wire logic                 dual_band,
  input  wire logic [1:0]           input_select,
  input  wire logic [31:0]          osc_word_0,
  input  wire logic [31:0]          osc_word_1,
  input  wire logic                 mixer_reload,
  input  wire logic                 sync_enable,
  input  wire logic                 sync_request,
  input  wire logic                 powerdown_align_pin,
  // status
  output logic                      powerdown,
  output logic [31:0]               active_word_0,
  output logic [31:0]               active_word_1,
  // formatter stream
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic signed [19:0]        out_i,
  output logic signed [19:0]        out_q,
  output logic                      out_lane,
  output logic                      out_is_complex
);
  localparam int CW = ddc_pkg::CALC_WIDTH;
  localparam int LUT_N = 1 << ddc_pkg::LUT_BITS;
  localparam int ACC_W = CW + ddc_pkg::DIV_WIDTH + 1;

  // pin synchroniser: change counts once stages two and three agree
  logic [ddc_pkg::SYNC_STAGES-1:0] pin_sr;
  logic pin_level;
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sr    <= '0;
      pin_level <= 1'b0;
    end else begin
      pin_sr <= {pin_sr[ddc_pkg::SYNC_STAGES-2:0], powerdown_align_pin};
      if (pin_sr[2] == pin_sr[1]) begin
        pin_level <= pin_sr[2];
      end
    end
  end

  logic pin_prev;
  logic reload_prev;
  logic sync_prev;
  logic sync_event;
  logic reload_event;
  assign powerdown = !sync_enable && pin_level;
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev    <= 1'b0;
      reload_prev <= 1'b0;
      sync_prev   <= 1'b0;
    end else begin
      pin_prev    <= pin_level;
      reload_prev <= mixer_reload;
      sync_prev   <= sync_request;
    end
  end
  // sync from pin toggle or register
  assign sync_event = (sync_enable && (pin_level != pin_prev)) || (sync_request && !sync_prev);
  assign reload_event = mixer_reload && !reload_prev;

  // quarter-wave sine table; coarse table limits spur floor
  function automatic logic signed [15:0] sine_of(input logic [ddc_pkg::PHASE_BITS-1:0] ph);
    logic [ddc_pkg::LUT_BITS-1:0] idx;
    logic signed [15:0] mag;
    idx = ph[ddc_pkg::LUT_BITS-1:0];
    if (ph[ddc_pkg::LUT_BITS]) begin
      idx = ~idx;
    end
    mag = 16'($rtoi(32767.0 * $sin(3.14159265358979 * (real'(idx) + 0.5) / (2.0 * LUT_N))));
    sine_of = ph[ddc_pkg::PHASE_BITS-1] ? -mag : mag;
  endfunction

  function automatic logic signed [19:0] clip(input logic signed [39:0] v);
    if (v > 40'(ddc_pkg::CALC_MAX)) begin
      clip = 20'(ddc_pkg::CALC_MAX);
    end else if (v < -40'(ddc_pkg::CALC_MAX) - 40'sh1) begin
      clip = 20'(-ddc_pkg::CALC_MAX - 1);
    end else begin
      clip = v[19:0];
    end
  endfunction

  // shared decimation divider
  logic [ddc_pkg::DIV_WIDTH-1:0] div_cnt;
  logic [ddc_pkg::DIV_WIDTH-1:0] div_last;
  logic                          dump;
  logic [2:0]                    dec_code;
  // codes above the largest factor behave as divide by 32
  assign dec_code = (dec_select > ddc_pkg::DEC_BY_32) ? ddc_pkg::DEC_BY_32 : dec_select;
  assign div_last = ddc_pkg::DIV_WIDTH'((2 << dec_code) - 1);
  assign dump     = sample_valid && (div_cnt == div_last);
  // divider reset aligns I and Q
  always_ff @(posedge clk) begin
    if (rst || sync_event) begin
      div_cnt <= '0;
    end else if (sample_valid) begin
      div_cnt <= dump ? '0 : div_cnt + 1'b1;
    end
  end

  logic signed [19:0] band_i [2];
  logic signed [19:0] band_q [2];
  logic [31:0] word_in [2];
  assign word_in[0] = osc_word_0;
  assign word_in[1] = osc_word_1;
  logic [31:0] act_word [2];
  assign active_word_0 = act_word[0];
  assign active_word_1 = act_word[1];

  for (genvar g = 0; g < 2; g++) begin : g_band
    logic signed [13:0] sel;
    logic [31:0]        phase;
    logic signed [ACC_W-1:0] acc_i;
    logic signed [ACC_W-1:0] acc_q;
    logic signed [19:0] x20;
    logic signed [19:0] mix_i;
    logic signed [19:0] mix_q;
    logic signed [15:0] s_v;
    logic signed [15:0] c_v;
    logic signed [35:0] pi;
    logic signed [35:0] pq;
    logic signed [ACC_W-1:0] avg_i;
    logic signed [ACC_W-1:0] avg_q;
    logic [15:0] gain;
    // wide product: the 6 dB factor must not wrap ahead of clip
    logic signed [42:0] prod_i;
    logic signed [42:0] prod_q;
    assign sel = input_select[g] ? sample_b : sample_a;
    // widen to 20-bit working precision
    // msb-aligned so the formatter only drops low bits
    assign x20 = {sel, 6'h00};
    assign s_v = phase_invert ? -sine_of(phase[31 -: ddc_pkg::PHASE_BITS]) : sine_of(phase[31 -: ddc_pkg::PHASE_BITS]);
    assign c_v = sine_of(phase[31 -: ddc_pkg::PHASE_BITS] + 8'h40);
    assign pi = x20 * c_v;
    assign pq = x20 * s_v;
    assign mix_i = complex_mode ? pi[34:15] : x20;
    assign mix_q = complex_mode ? pq[34:15] : 20'sh0;
    // word becomes active only on reload or sync
    always_ff @(posedge clk) begin
      if (rst) begin
        act_word[g] <= '0;
      end else if (reload_event || sync_event) begin
        act_word[g] <= word_in[g];
      end
    end
    // signed wrap phase accumulator, lsb = rate/2^32
    always_ff @(posedge clk) begin
      if (rst || reload_event || sync_event) begin
        phase <= '0;
      end else if (sample_valid) begin
        phase <= phase + act_word[g];
      end
    end
    // boxcar low-pass then decimate; stop-band depends on downstream
    always_ff @(posedge clk) begin
      if (rst || sync_event) begin
        acc_i <= '0;
        acc_q <= '0;
      end else if (sample_valid) begin
        acc_i <= dump ? '0 : acc_i + ACC_W'(mix_i);
        acc_q <= dump ? '0 : acc_q + ACC_W'(mix_q);
      end
    end
    assign avg_i = (acc_i + ACC_W'(mix_i)) >>> (dec_code + 3'h1);
    assign avg_q = (acc_q + ACC_W'(mix_q)) >>> (dec_code + 3'h1);
    assign gain = !gain_enable ? ddc_pkg::GAIN_UNITY : complex_mode ? ddc_pkg::GAIN_6DB : ddc_pkg::GAIN_3DB;
    assign prod_i = avg_i * $signed({1'b0, gain});
    assign prod_q = avg_q * $signed({1'b0, gain});
    assign band_i[g] = clip(40'(prod_i >>> ddc_pkg::GAIN_FRAC));
    assign band_q[g] = clip(40'(prod_q >>> ddc_pkg::GAIN_FRAC));
  end

  // quarter-rate rotation state, steps per decimated output
  logic [1:0] qr_step;
  always_ff @(posedge clk) begin
    if (rst || sync_event) begin
      qr_step <= '0;
    end else if (dump) begin
      qr_step <= qr_step + 2'h2;
    end
  end

  // output issue: up to two words per decimated sample
  localparam int FW = 2 * CW + 2;
  logic [FW-1:0] fifo_in;
  logic          fifo_valid;
  logic          fifo_ready;
  logic [FW-1:0] pend;
  logic          pend_valid;
  logic [FW-1:0] first_word;
  logic [FW-1:0] second_word;
  logic signed [19:0] r0;
  logic signed [19:0] r1;
  // e^{j pi n/2}: two real samples per complex output
  always_comb begin
    case (qr_step)
      2'h0: begin
        r0 = band_i[0];
        r1 = clip(-40'(band_q[0]));
      end
      default: begin
        r0 = clip(-40'(band_i[0]));
        r1 = band_q[0];
      end
    endcase
  end
  // I and Q travel together for the mapper
  assign first_word = (complex_mode && quarter_rate_mode) ? {ddc_pkg::LANE_FIRST, 1'b0, r0, 20'sh0}
                      : {ddc_pkg::LANE_FIRST, complex_mode, band_i[0], band_q[0]};
  // second band on second lane pair; in quarter-rate, band 0 r1 goes on the first lane pair
  assign second_word = (complex_mode && quarter_rate_mode) ? {ddc_pkg::LANE_FIRST, 1'b0, r1, 20'sh0}
                       : {ddc_pkg::LANE_SECOND, complex_mode, band_i[1], band_q[1]};
  // decimated samples only while the filter is on
  // quarter-rate splits band 0 only; band 1 is idle there
  logic need_second;
  assign need_second = (complex_mode && quarter_rate_mode) || dual_band;
  // pend holds the second word; a dump during stall is dropped
  assign fifo_valid = pend_valid || (filter_enable && dump);
  assign fifo_in    = pend_valid ? pend : first_word;
  always_ff @(posedge clk) begin
    if (rst || sync_event) begin
      pend_valid <= 1'b0;
      pend       <= '0;
    end else if (pend_valid) begin
      if (fifo_ready) begin
        pend_valid <= 1'b0;
      end
    end else if (filter_enable && dump && need_second) begin
      pend_valid <= 1'b1;
      pend       <= second_word;
    end
  end

  // sixteen words only ride out short formatter stalls
  logic [FW-1:0] fifo_out;
  ddc_fifo #(
    .WIDTH (FW),
    .DEPTH (ddc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_valid),
    .in_ready  (fifo_ready),
    .in_data   (fifo_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out)
  );
  assign out_lane       = fifo_out[FW-1];
  assign out_is_complex = fifo_out[FW-2];
  assign out_i          = fifo_out[2*CW-1:CW];
  assign out_q          = fifo_out[CW-1:0];
endmodule // ddc_core

// [ddc_fifo.sv]
// small synchronous fifo between the converters and the formatter
`timescale 1ns/10ps
module ddc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // ddc_fifo

// [ddc_pkg.sv]
// shared constants for the dual band down converter
package ddc_pkg;
  localparam int SAMPLE_WIDTH = 14;
  localparam int CALC_WIDTH   = 20;
  localparam int FREQ_WIDTH   = 32;
  localparam int PHASE_BITS   = 8;
  localparam int LUT_BITS     = 6;
  localparam int CALC_MAX     = (1 << (CALC_WIDTH - 1)) - 1;
  localparam int DIV_WIDTH    = 5;
  localparam int FIFO_DEPTH   = 16;
  localparam int SYNC_STAGES  = 3;
  // decimation select codes: factor = 2 << code
  localparam logic [2:0] DEC_BY_2  = 3'h0;
  localparam logic [2:0] DEC_BY_32 = 3'h4;
  // fixed gain multipliers, q1.14 format
  localparam logic [15:0] GAIN_6DB  = 16'h7fd9;
  localparam logic [15:0] GAIN_3DB  = 16'h5a9e;
  localparam int          GAIN_FRAC = 14;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  // lane pair select for each output word
  localparam logic LANE_FIRST  = 1'b0;
  localparam logic LANE_SECOND = 1'b1;
endpackage

// [formatter_model.sv]
// formatter side model: takes words from the converter stream
`timescale 1ns/10ps
module formatter_model (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // bench control
  input wire logic               stall,
  // converter stream
  input wire logic               out_valid,
  output logic                   out_ready,
  input wire logic signed [19:0] out_i,
  input wire logic signed [19:0] out_q,
  input wire logic               out_lane,
  input wire logic               out_is_complex
);
  // lane, complex flag, q, i
  logic [41:0] words[$];
  always @(posedge clk) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        words.push_back({out_lane, out_is_complex, out_q, out_i});
      end
      out_ready <= !stall;
    end
  end
endmodule // formatter_model

// [testbench.sv]
// self-checking bench for the down converter
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
  logic clk = 1'b0, rst = 1'b1, sample_valid = 1'b0, filter_enable = 1'b1, complex_mode = 1'b0;
  logic gain_enable = 1'b0, quarter_rate_mode = 1'b0, phase_invert = 1'b0, dual_band = 1'b0;
  logic mixer_reload = 1'b0, sync_enable = 1'b0, sync_request = 1'b0, pin = 1'b0, stall = 1'b0;
  logic signed [13:0] sample_a = 14'h0, sample_b = 14'h0;
  logic [2:0] dec_select = 3'h0;
  logic [1:0] input_select = 2'h0;
  logic [31:0] osc_word_0 = 32'h0, osc_word_1 = 32'h0, active_word_0, active_word_1;
  logic powerdown, out_valid, out_ready, out_lane, out_is_complex;
  logic signed [19:0] out_i, out_q;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  always #10 clk = ~clk;
  ddc_core u_ddc_core (.clk(clk), .rst(rst), .sample_valid(sample_valid), .sample_a(sample_a),
    .sample_b(sample_b), .filter_enable(filter_enable), .complex_mode(complex_mode), .dec_select(dec_select),
    .gain_enable(gain_enable), .quarter_rate_mode(quarter_rate_mode), .phase_invert(phase_invert),
    .dual_band(dual_band), .input_select(input_select), .osc_word_0(osc_word_0), .osc_word_1(osc_word_1),
    .mixer_reload(mixer_reload), .sync_enable(sync_enable), .sync_request(sync_request),
    .powerdown_align_pin(pin), .powerdown(powerdown), .active_word_0(active_word_0),
    .active_word_1(active_word_1), .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i),
    .out_q(out_q), .out_lane(out_lane), .out_is_complex(out_is_complex));
  formatter_model sink (.clk(clk), .rst(rst), .stall(stall), .out_valid(out_valid), .out_ready(out_ready),
    .out_i(out_i), .out_q(out_q), .out_lane(out_lane), .out_is_complex(out_is_complex));
  task automatic results;
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // whole run needs about 800 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // register sync first, so every dump count starts from divider zero
  task automatic feed(input int n);
    sink.words.delete();
    sync_request = 1'b1;
    tick(2);
    sync_request = 1'b0;
    tick(3);
    sample_valid = 1'b1;
    tick(n);
    sample_valid = 1'b0;
    tick(12);
  endtask
  task automatic check_words(input int n, input logic [41:0] even, input logic [41:0] odd);
    `CHK(sink.words.size(), n)
    for (int k = 0; k < n; k++) begin
      `CHK(sink.words[k], (k % 2) ? odd : even)
    end
  endtask
  task automatic t_load;
    `CHK(active_word_0, 32'h0)
    osc_word_0 = 32'h8000_0001;
    tick(3);
    `CHK(active_word_0, 32'h0)
    mixer_reload = 1'b1;
    tick(3);
    mixer_reload = 1'b0;
    `CHK(active_word_0, 32'h8000_0001)
    osc_word_1 = 32'h1234_5678;
    sync_request = 1'b1;
    tick(3);
    sync_request = 1'b0;
    `CHK(active_word_1, 32'h1234_5678)
    $display("test load done");
  endtask
  task automatic t_pin;
    pin = 1'b1;
    tick(8);
    `CHK(powerdown, 1'b1)
    sync_enable = 1'b1;
    osc_word_0 = 32'h0;
    tick(1);
    `CHK(powerdown, 1'b0)
    // toggle on a 64 cycle boundary
    tick(63);
    pin = 1'b0;
    tick(8);
    `CHK(active_word_0, 32'h0)
    sync_enable = 1'b0;
    $display("test pin done");
  endtask
  task automatic t_real;
    sample_a = -14'sd100;
    feed(8);
    check_words(4, {22'h0, 20'hfe700}, {22'h0, 20'hfe700});
    sample_a = 14'sd100;
    for (int c = 0; c < 5; c++) begin
      dec_select = c[2:0];
      feed(64);
      `CHK(sink.words.size(), 64 >> (c + 1))
    end
    dec_select = 3'h0;
    dual_band = 1'b1;
    input_select = 2'b10;
    sample_b = -14'sd50;
    feed(4);
    check_words(4, {22'h0, 20'h01900}, {2'b10, 20'h0, 20'hff380});
    dual_band = 1'b0;
    $display("test real done");
  endtask
  task automatic t_complex;
    complex_mode = 1'b1;
    dec_select = 3'h1;
    feed(8);
    `CHK(sink.words.size(), 2)
    `CHK(sink.words[1][41:40], 2'b01)
    quarter_rate_mode = 1'b1;
    dec_select = 3'h0;
    feed(4);
    `CHK(sink.words.size(), 4)
    `CHK(sink.words[3][41:40], 2'b00)
    quarter_rate_mode = 1'b0;
    complex_mode = 1'b0;
    $display("test complex done");
  endtask
  task automatic t_gain;
    // gain chosen first, then update bit set and cleared
    gain_enable = 1'b1;
    tick(2);
    mixer_reload = 1'b1;
    tick(2);
    mixer_reload = 1'b0;
    feed(4);
    check_words(2, {22'h0, 20'h02365}, {22'h0, 20'h02365});
    sample_a = 14'sh1fff;
    feed(4);
    check_words(2, {22'h0, 20'h7ffff}, {22'h0, 20'h7ffff});
    complex_mode = 1'b1;
    feed(4);
    `CHK(sink.words[0][19:0], 20'h7ffff)
    complex_mode = 1'b0;
    gain_enable = 1'b0;
    filter_enable = 1'b0;
    feed(8);
    `CHK(sink.words.size(), 0)
    filter_enable = 1'b1;
    sample_a = 14'sd100;
    $display("test gain done");
  endtask
  task automatic t_fill;
    stall = 1'b1;
    feed(60);
    `CHK(out_valid, 1'b1)
    stall = 1'b0;
    tick(30);
    `CHK(sink.words.size() >= 16, 1'b1)
    `CHK(out_valid, 1'b0)
    $display("test fill done");
  endtask
  initial begin
    tick(16);
    rst = 1'b0;
    tick(2);
    t_load();
    t_pin();
    t_real();
    t_complex();
    t_gain();
    t_fill();
    results();
  end
endmodule // testbench
